// *** pkg/dtd_pkg.sv ***
// Constants and types for the data-transfer instruction decoder
// Overview of operation
// - Reg to reg/mem copy: 2 or 3
// - Reg/mem to reg copy: 2 or 5
// - Immediate to reg/mem copy: 2 or 3
// - Short immediate to register copy: 2
// - Memory to accumulator copy: 5
// - Accumulator to memory copy: 3
// - Segment load: 2/5 real, 17/19 protected
// - Segment store to reg/mem: 2 or 3
// - Stack store memory operand: 5
// - Stack store register or segment: 3
// - Stack store immediate, s picks length: 3
// - Store all registers: 17
// - Stack load into memory operand: 5
// - Stack load into register: 5
// - Load all registers: 19
// - Reg/mem swap 3 or 5, bus lock
// - Register with accumulator swap: 3
// - Port read, fixed or register: 5
// - Port write, fixed or register: 3
// - Byte table lookup: 5
// - Width bit one means word
// - Sign bit one extends one byte
// - Smaller cost register, larger memory, except stack load (5 both)
// - Protected port access needs privilege check
package dtd_pkg;
    // ****************************************
    // Operation classes
    // ****************************************
    typedef enum logic [4:0] {
        DTD_NONE = 5'h00,
        DTD_COPY_RM_FROM_REG = 5'h01,
        DTD_COPY_REG_FROM_RM = 5'h02,
        DTD_COPY_IMM_RM = 5'h03,
        DTD_COPY_IMM_REG = 5'h04,
        DTD_COPY_MEM_ACC = 5'h05,
        DTD_COPY_ACC_MEM = 5'h06,
        DTD_SEG_LOAD = 5'h07,
        DTD_SEG_STORE = 5'h08,
        DTD_PUSH_MEM = 5'h09,
        DTD_PUSH_REG = 5'h0a,
        DTD_PUSH_SEG = 5'h0b,
        DTD_PUSH_IMM = 5'h0c,
        DTD_STORE_ALL = 5'h0d,
        DTD_POP_MEM = 5'h0e,
        DTD_POP_REG = 5'h0f,
        DTD_LOAD_ALL = 5'h10,
        DTD_SWAP_RM = 5'h11,
        DTD_SWAP_ACC = 5'h12,
        DTD_IN_FIXED = 5'h13,
        DTD_IN_VAR = 5'h14,
        DTD_OUT_FIXED = 5'h15,
        DTD_OUT_VAR = 5'h16,
        DTD_LOOKUP = 5'h17
    } dtd_op_t;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int DTD_W_BIT = 0;
    localparam int DTD_S_BIT = 1;
    localparam int DTD_SHORT_W_BIT = 3;
    localparam int DTD_MOD_HI = 7;
    localparam int DTD_MOD_LO = 6;
    localparam int DTD_REG_HI = 5;
    localparam int DTD_REG_LO = 3;
    localparam logic [1:0] DTD_MOD_REGISTER = 2'h3;
    localparam logic [2:0] DTD_REG_PUSH_MEM = 3'h6;
    localparam logic [2:0] DTD_REG_ZERO = 3'h0;

    // ****************************************
    // Clock costs
    // ****************************************
    localparam logic [4:0] DTD_CLK_2 = 5'h02;
    localparam logic [4:0] DTD_CLK_3 = 5'h03;
    localparam logic [4:0] DTD_CLK_5 = 5'h05;
    localparam logic [4:0] DTD_CLK_17 = 5'h11;
    localparam logic [4:0] DTD_CLK_19 = 5'h13;

    // ****************************************
    // Exceptions and reset values
    // ****************************************
    localparam logic [7:0] DTD_EXC_GP = 8'h0d;
    localparam logic [7:0] DTD_EXC_NONE = 8'h00;
    localparam logic [4:0] DTD_CLK_RESET = 5'h00;
endpackage

// *** hw/dtd_cost.sv ***
// Clock cost lookup for a decoded data-transfer operation
`timescale 1ns/100ps
module dtd_cost (
    input wire dtd_pkg::dtd_op_t op_in,
    input wire logic mem_operand_in,
    input wire logic protected_mode_in,
    output logic [4:0] clocks_out
);
    always_comb begin
        clocks_out = dtd_pkg::DTD_CLK_RESET;
        unique case (op_in)
            dtd_pkg::DTD_COPY_RM_FROM_REG,
            dtd_pkg::DTD_COPY_IMM_RM,
            dtd_pkg::DTD_SEG_STORE: begin
                clocks_out = mem_operand_in ? dtd_pkg::DTD_CLK_3 : dtd_pkg::DTD_CLK_2;
            end
            dtd_pkg::DTD_COPY_REG_FROM_RM: begin
                clocks_out = mem_operand_in ? dtd_pkg::DTD_CLK_5 : dtd_pkg::DTD_CLK_2;
            end
            dtd_pkg::DTD_COPY_IMM_REG: begin
                clocks_out = dtd_pkg::DTD_CLK_2;
            end
            dtd_pkg::DTD_SEG_LOAD: begin
                if (protected_mode_in) begin
                    clocks_out = mem_operand_in ? dtd_pkg::DTD_CLK_19 : dtd_pkg::DTD_CLK_17;
                end else begin
                    clocks_out = mem_operand_in ? dtd_pkg::DTD_CLK_5 : dtd_pkg::DTD_CLK_2;
                end
            end
            dtd_pkg::DTD_SWAP_RM: begin
                clocks_out = mem_operand_in ? dtd_pkg::DTD_CLK_5 : dtd_pkg::DTD_CLK_3;
            end
            dtd_pkg::DTD_COPY_MEM_ACC,
            dtd_pkg::DTD_PUSH_MEM,
            dtd_pkg::DTD_POP_MEM,
            dtd_pkg::DTD_POP_REG,
            dtd_pkg::DTD_IN_FIXED,
            dtd_pkg::DTD_IN_VAR,
            dtd_pkg::DTD_LOOKUP: begin
                clocks_out = dtd_pkg::DTD_CLK_5;
            end
            dtd_pkg::DTD_COPY_ACC_MEM,
            dtd_pkg::DTD_PUSH_REG,
            dtd_pkg::DTD_PUSH_SEG,
            dtd_pkg::DTD_PUSH_IMM,
            dtd_pkg::DTD_SWAP_ACC,
            dtd_pkg::DTD_OUT_FIXED,
            dtd_pkg::DTD_OUT_VAR: begin
                clocks_out = dtd_pkg::DTD_CLK_3;
            end
            dtd_pkg::DTD_STORE_ALL: begin
                clocks_out = dtd_pkg::DTD_CLK_17;
            end
            dtd_pkg::DTD_LOAD_ALL: begin
                clocks_out = dtd_pkg::DTD_CLK_19;
            end
            default: begin
                clocks_out = dtd_pkg::DTD_CLK_RESET;
            end
        endcase
    end
endmodule

// *** hw/dtd_decode.sv ***
// Data-transfer instruction group decoder, registered result
`timescale 1ns/100ps
module dtd_decode (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] modrm_in,
    input wire logic protected_mode_in,
    input wire logic [1:0] current_privilege_level_in,
    input wire logic [1:0] io_privilege_level_in,
    output logic valid_out,
    output logic in_group_out,
    output logic not_in_group_out,
    output logic [4:0] op_out,
    output logic [4:0] clocks_out,
    output logic word_op_out,
    output logic sign_extend_out,
    output logic needs_modrm_out,
    output logic [2:0] imm_bytes_out,
    output logic [1:0] addr_bytes_out,
    output logic port_byte_out,
    output logic [2:0] reg_sel_out,
    output logic bus_lock_out,
    output logic exception_out,
    output logic [7:0] exception_vector_out
);
    // ****************************************
    // Opcode classification
    // ****************************************
    dtd_pkg::dtd_op_t dec_op;
    logic dec_modrm;
    logic dec_word;
    logic dec_sext;
    logic [2:0] dec_imm;
    logic [1:0] dec_addr;
    logic dec_port;
    logic [2:0] dec_reg;
    logic mem_operand;
    logic [4:0] cost;
    logic [1:0] modf;
    logic [2:0] regf;

    assign modf = modrm_in[dtd_pkg::DTD_MOD_HI:dtd_pkg::DTD_MOD_LO];
    assign regf = modrm_in[dtd_pkg::DTD_REG_HI:dtd_pkg::DTD_REG_LO];
    assign mem_operand = dec_modrm && (modf != dtd_pkg::DTD_MOD_REGISTER);

    always_comb begin
        dec_op = dtd_pkg::DTD_NONE;
        dec_modrm = 1'b0;
        dec_word = opcode_in[dtd_pkg::DTD_W_BIT];
        dec_sext = 1'b0;
        dec_imm = 3'h0;
        dec_addr = 2'h0;
        dec_port = 1'b0;
        dec_reg = opcode_in[2:0];
        if (opcode_in[7:1] == 7'h44) begin
            dec_op = dtd_pkg::DTD_COPY_RM_FROM_REG;
            dec_modrm = 1'b1;
        end else if (opcode_in[7:1] == 7'h45) begin
            dec_op = dtd_pkg::DTD_COPY_REG_FROM_RM;
            dec_modrm = 1'b1;
        end else if (opcode_in[7:1] == 7'h63 && regf == dtd_pkg::DTD_REG_ZERO) begin
            dec_op = dtd_pkg::DTD_COPY_IMM_RM;
            dec_modrm = 1'b1;
            dec_imm = opcode_in[dtd_pkg::DTD_W_BIT] ? 3'h2 : 3'h1;
        end else if (opcode_in[7:4] == 4'hb) begin
            dec_op = dtd_pkg::DTD_COPY_IMM_REG;
            dec_word = opcode_in[dtd_pkg::DTD_SHORT_W_BIT];
            dec_imm = opcode_in[dtd_pkg::DTD_SHORT_W_BIT] ? 3'h2 : 3'h1;
        end else if (opcode_in[7:1] == 7'h50) begin
            dec_op = dtd_pkg::DTD_COPY_MEM_ACC;
            dec_addr = 2'h2;
        end else if (opcode_in[7:1] == 7'h51) begin
            dec_op = dtd_pkg::DTD_COPY_ACC_MEM;
            dec_addr = 2'h2;
        end else if (opcode_in == 8'h8e) begin
            dec_op = dtd_pkg::DTD_SEG_LOAD;
            dec_modrm = 1'b1;
            dec_word = 1'b1;
        end else if (opcode_in == 8'h8c) begin
            dec_op = dtd_pkg::DTD_SEG_STORE;
            dec_modrm = 1'b1;
            dec_word = 1'b1;
        end else if (opcode_in == 8'hff && regf == dtd_pkg::DTD_REG_PUSH_MEM) begin
            dec_op = dtd_pkg::DTD_PUSH_MEM;
            dec_modrm = 1'b1;
            dec_word = 1'b1;
        end else if (opcode_in[7:3] == 5'h0a) begin
            dec_op = dtd_pkg::DTD_PUSH_REG;
            dec_word = 1'b1;
        end else if (opcode_in[7:5] == 3'h0 && opcode_in[2:0] == 3'h6) begin
            dec_op = dtd_pkg::DTD_PUSH_SEG;
            dec_word = 1'b1;
            dec_reg = opcode_in[5:3];
        end else if ((opcode_in & 8'hfd) == 8'h68) begin
            dec_op = dtd_pkg::DTD_PUSH_IMM;
            dec_word = 1'b1;
            dec_sext = opcode_in[dtd_pkg::DTD_S_BIT];
            dec_imm = opcode_in[dtd_pkg::DTD_S_BIT] ? 3'h1 : 3'h2;
        end else if (opcode_in == 8'h60) begin
            dec_op = dtd_pkg::DTD_STORE_ALL;
            dec_word = 1'b1;
        end else if (opcode_in == 8'h8f && regf == dtd_pkg::DTD_REG_ZERO) begin
            dec_op = dtd_pkg::DTD_POP_MEM;
            dec_modrm = 1'b1;
            dec_word = 1'b1;
        end else if (opcode_in[7:3] == 5'h0b) begin
            dec_op = dtd_pkg::DTD_POP_REG;
            dec_word = 1'b1;
        end else if (opcode_in == 8'h61) begin
            dec_op = dtd_pkg::DTD_LOAD_ALL;
            dec_word = 1'b1;
        end else if (opcode_in[7:1] == 7'h43) begin
            dec_op = dtd_pkg::DTD_SWAP_RM;
            dec_modrm = 1'b1;
        end else if (opcode_in[7:3] == 5'h12) begin
            dec_op = dtd_pkg::DTD_SWAP_ACC;
            dec_word = 1'b1;
        end else if (opcode_in[7:1] == 7'h72) begin
            dec_op = dtd_pkg::DTD_IN_FIXED;
            dec_port = 1'b1;
        end else if (opcode_in[7:1] == 7'h76) begin
            dec_op = dtd_pkg::DTD_IN_VAR;
        end else if (opcode_in[7:1] == 7'h73) begin
            dec_op = dtd_pkg::DTD_OUT_FIXED;
            dec_port = 1'b1;
        end else if (opcode_in[7:1] == 7'h77) begin
            dec_op = dtd_pkg::DTD_OUT_VAR;
        end else if (opcode_in == 8'hd7) begin
            dec_op = dtd_pkg::DTD_LOOKUP;
            dec_word = 1'b0;
        end
        if (dec_modrm) begin
            dec_reg = regf;
        end
        if (dec_op == dtd_pkg::DTD_NONE) begin
            dec_word = 1'b0;
            dec_reg = 3'h0;
        end
    end

    dtd_cost u_cost (
        .op_in(dec_op),
        .mem_operand_in(mem_operand),
        .protected_mode_in(protected_mode_in),
        .clocks_out(cost)
    );

    // ****************************************
    // Side effects and exceptions
    // ****************************************
    logic is_port;
    logic dec_exc;
    logic dec_lock;

    assign is_port = (dec_op == dtd_pkg::DTD_IN_FIXED) || (dec_op == dtd_pkg::DTD_IN_VAR) ||
                     (dec_op == dtd_pkg::DTD_OUT_FIXED) || (dec_op == dtd_pkg::DTD_OUT_VAR);
    assign dec_exc = is_port && protected_mode_in &&
                     (current_privilege_level_in > io_privilege_level_in);
    assign dec_lock = (dec_op == dtd_pkg::DTD_SWAP_RM);

    // ****************************************
    // Output registers
    // ****************************************
    logic next_valid;
    logic next_in_group;
    logic [4:0] next_op;
    logic [4:0] next_clocks;
    logic next_word;
    logic next_sext;
    logic next_modrm;
    logic [2:0] next_imm;
    logic [1:0] next_addr;
    logic next_port;
    logic [2:0] next_reg;
    logic next_lock;
    logic next_exc;
    logic [7:0] next_vec;

    always_comb begin
        next_valid = valid_in;
        next_in_group = valid_in && (dec_op != dtd_pkg::DTD_NONE);
        next_op = valid_in ? dec_op : dtd_pkg::DTD_NONE;
        next_clocks = valid_in ? cost : dtd_pkg::DTD_CLK_RESET;
        next_word = valid_in && dec_word;
        next_sext = valid_in && dec_sext;
        next_modrm = valid_in && dec_modrm;
        next_imm = valid_in ? dec_imm : 3'h0;
        next_addr = valid_in ? dec_addr : 2'h0;
        next_port = valid_in && dec_port;
        next_reg = valid_in ? dec_reg : 3'h0;
        next_lock = valid_in && dec_lock;
        next_exc = valid_in && dec_exc;
        next_vec = (valid_in && dec_exc) ? dtd_pkg::DTD_EXC_GP : dtd_pkg::DTD_EXC_NONE;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            valid_out <= 1'b0;
            in_group_out <= 1'b0;
            op_out <= 5'h00;
            clocks_out <= dtd_pkg::DTD_CLK_RESET;
            word_op_out <= 1'b0;
            sign_extend_out <= 1'b0;
            needs_modrm_out <= 1'b0;
            imm_bytes_out <= 3'h0;
            addr_bytes_out <= 2'h0;
            port_byte_out <= 1'b0;
            reg_sel_out <= 3'h0;
            bus_lock_out <= 1'b0;
            exception_out <= 1'b0;
            exception_vector_out <= dtd_pkg::DTD_EXC_NONE;
        end else begin
            valid_out <= next_valid;
            in_group_out <= next_in_group;
            op_out <= next_op;
            clocks_out <= next_clocks;
            word_op_out <= next_word;
            sign_extend_out <= next_sext;
            needs_modrm_out <= next_modrm;
            imm_bytes_out <= next_imm;
            addr_bytes_out <= next_addr;
            port_byte_out <= next_port;
            reg_sel_out <= next_reg;
            bus_lock_out <= next_lock;
            exception_out <= next_exc;
            exception_vector_out <= next_vec;
        end
    end

    assign not_in_group_out = valid_out && !in_group_out;
endmodule

// *** testbench/dtd_decode_checker.sv ***
// Assertion checker for the data-transfer decoder
`timescale 1ns/100ps
module dtd_decode_checker (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] modrm_in,
    input wire logic protected_mode_in,
    input wire logic [1:0] current_privilege_level_in,
    input wire logic [1:0] io_privilege_level_in,
    input wire logic valid_out,
    input wire logic in_group_out,
    input wire logic not_in_group_out,
    input wire logic [4:0] op_out,
    input wire logic [4:0] clocks_out,
    input wire logic word_op_out,
    input wire logic bus_lock_out,
    input wire logic exception_out,
    input wire logic [7:0] exception_vector_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // ****************************************
    // Request shapes
    // ****************************************
    sequence port_req;
        valid_in && opcode_in[7:4] == 4'he && opcode_in[2];
    endsequence
    sequence port_denied;
        port_req ##0 (protected_mode_in && current_privilege_level_in > io_privilege_level_in);
    endsequence
    // ****************************************
    // Properties
    // ****************************************
    store_all_a: assert property (valid_in && opcode_in == 8'h60 |=> in_group_out && clocks_out == 5'h11)
        else $error("store all cost wrong");
    load_all_a: assert property (valid_in && opcode_in == 8'h61 |=> clocks_out == 5'h13)
        else $error("load all cost wrong");
    seg_load_prot_a: assert property (valid_in && opcode_in == 8'h8e && protected_mode_in
        && modrm_in[7:6] != 2'h3 |=> clocks_out == 5'h13) else $error("segment load cost wrong");
    reg_copy_cost_a: assert property (valid_in && opcode_in[7:1] == 7'h44
        && modrm_in[7:6] == 2'h3 |=> clocks_out == 5'h02) else $error("register copy cost wrong");
    width_bit_a: assert property (valid_in && opcode_in[7:1] == 7'h45
        |=> word_op_out == $past(opcode_in[0])) else $error("width bit wrong");
    swap_lock_a: assert property (valid_in && opcode_in[7:1] == 7'h43 |=> bus_lock_out)
        else $error("swap without lock");
    lock_only_swap_a: assert property (bus_lock_out |-> op_out == 5'h11)
        else $error("lock on other form");
    port_fault_a: assert property (port_denied |=> exception_out && exception_vector_out == 8'h0d)
        else $error("port fault missing");
    port_real_a: assert property (port_req ##0 !protected_mode_in |=> !exception_out)
        else $error("port fault in real mode");
    other_group_a: assert property (valid_in && opcode_in == 8'h0f
        |=> not_in_group_out && op_out == 5'h00) else $error("foreign opcode claimed");
endmodule
bind dtd_decode dtd_decode_checker chk (.clk_sys_in, .resetn_in, .valid_in, .opcode_in,
    .modrm_in, .protected_mode_in, .current_privilege_level_in, .io_privilege_level_in,
    .valid_out, .in_group_out, .not_in_group_out, .op_out, .clocks_out, .word_op_out,
    .bus_lock_out, .exception_out, .exception_vector_out);

// *** testbench/dtd_decode_tb.sv ***
// Self-checking testbench for the data-transfer decoder
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module dtd_decode_tb;
    logic clk_sys_in, resetn_in, valid_in, protected_mode_in;
    logic [7:0] opcode_in, modrm_in;
    logic [1:0] current_privilege_level_in, io_privilege_level_in;
    logic valid_out, in_group_out, not_in_group_out, word_op_out, sign_extend_out;
    logic needs_modrm_out, port_byte_out, bus_lock_out, exception_out;
    logic [4:0] op_out, clocks_out;
    logic [2:0] imm_bytes_out, reg_sel_out;
    logic [1:0] addr_bytes_out;
    logic [7:0] exception_vector_out;
    int failures = 0;
    int total_checks = 0;

    dtd_decode uut (.clk_sys_in, .resetn_in, .valid_in, .opcode_in, .modrm_in,
        .protected_mode_in, .current_privilege_level_in, .io_privilege_level_in,
        .valid_out, .in_group_out, .not_in_group_out, .op_out, .clocks_out, .word_op_out,
        .sign_extend_out, .needs_modrm_out, .imm_bytes_out, .addr_bytes_out, .port_byte_out,
        .reg_sel_out, .bus_lock_out, .exception_out, .exception_vector_out);

    // ****************************************
    // Helpers
    // ****************************************
    task automatic run(input logic [7:0] opc, input logic [7:0] mrm, input logic prot,
            input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
        valid_in = 1'b1;
        opcode_in = opc;
        modrm_in = mrm;
        protected_mode_in = prot;
        current_privilege_level_in = current_privilege_level;
        io_privilege_level_in = io_privilege_level;
        @(negedge clk_sys_in);
    endtask

    task automatic form(input logic [7:0] opc, input logic [7:0] mrm, input logic prot,
            input logic [4:0] op, input logic [4:0] clk);
        run(opc, mrm, prot, 2'h0, 2'h0);
        `CHK(valid_out, 1'b1)
        `CHK(not_in_group_out, op == 5'h00)
        `CHK(in_group_out, op != 5'h00)
        `CHK(op_out, op)
        `CHK(clocks_out, clk)
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        `CHK(valid_out, 1'b0)
        `CHK(op_out, 5'h00)
        run(8'h60, 8'h00, 1'b0, 2'h0, 2'h0);
        `CHK(clocks_out, 5'h11)
        resetn_in = 1'b0;
        #1;
        `CHK(clocks_out, 5'h00)
        @(negedge clk_sys_in);
        resetn_in = 1'b1;
    endtask

    task automatic t_copies();
        form(8'h88, 8'hc0, 1'b0, 5'h01, 5'h02);
        form(8'h89, 8'h06, 1'b1, 5'h01, 5'h03);
        `CHK(word_op_out, 1'b1)
        form(8'h8a, 8'hc1, 1'b0, 5'h02, 5'h02);
        `CHK(word_op_out, 1'b0)
        form(8'h8b, 8'h06, 1'b0, 5'h02, 5'h05);
        `CHK(needs_modrm_out, 1'b1)
        form(8'hc6, 8'hc0, 1'b0, 5'h03, 5'h02);
        `CHK(imm_bytes_out, 3'h1)
        form(8'hc7, 8'h06, 1'b0, 5'h03, 5'h03);
        `CHK(imm_bytes_out, 3'h2)
        form(8'hc6, 8'h08, 1'b0, 5'h00, 5'h00);
        form(8'hb3, 8'h00, 1'b0, 5'h04, 5'h02);
        `CHK(imm_bytes_out, 3'h1)
        `CHK(reg_sel_out, 3'h3)
        form(8'hbf, 8'h00, 1'b0, 5'h04, 5'h02);
        `CHK(imm_bytes_out, 3'h2)
        form(8'ha1, 8'h00, 1'b1, 5'h05, 5'h05);
        `CHK(addr_bytes_out, 2'h2)
        form(8'ha2, 8'h00, 1'b0, 5'h06, 5'h03);
        `CHK(addr_bytes_out, 2'h2)
    endtask

    task automatic t_segs();
        form(8'h8e, 8'hd8, 1'b0, 5'h07, 5'h02);
        form(8'h8e, 8'h06, 1'b0, 5'h07, 5'h05);
        form(8'h8e, 8'hd8, 1'b1, 5'h07, 5'h11);
        form(8'h8e, 8'h06, 1'b1, 5'h07, 5'h13);
        form(8'h8c, 8'hc0, 1'b1, 5'h08, 5'h02);
        form(8'h8c, 8'h06, 1'b0, 5'h08, 5'h03);
    endtask

    task automatic t_stack();
        form(8'hff, 8'h36, 1'b0, 5'h09, 5'h05);
        form(8'hff, 8'h06, 1'b0, 5'h00, 5'h00);
        form(8'h53, 8'h00, 1'b0, 5'h0a, 5'h03);
        `CHK(reg_sel_out, 3'h3)
        form(8'h1e, 8'h00, 1'b0, 5'h0b, 5'h03);
        form(8'h6a, 8'h00, 1'b0, 5'h0c, 5'h03);
        `CHK(sign_extend_out, 1'b1)
        `CHK(imm_bytes_out, 3'h1)
        form(8'h68, 8'h00, 1'b0, 5'h0c, 5'h03);
        `CHK(imm_bytes_out, 3'h2)
        form(8'h60, 8'h00, 1'b1, 5'h0d, 5'h11);
        form(8'h8f, 8'h06, 1'b0, 5'h0e, 5'h05);
        form(8'h8f, 8'h08, 1'b0, 5'h00, 5'h00);
        form(8'h5a, 8'h00, 1'b0, 5'h0f, 5'h05);
        `CHK(reg_sel_out, 3'h2)
        form(8'h61, 8'h00, 1'b1, 5'h10, 5'h13);
    endtask

    task automatic t_swaps();
        form(8'h87, 8'hc3, 1'b0, 5'h11, 5'h03);
        `CHK(bus_lock_out, 1'b1)
        form(8'h86, 8'h06, 1'b0, 5'h11, 5'h05);
        form(8'h93, 8'h00, 1'b0, 5'h12, 5'h03);
        `CHK(bus_lock_out, 1'b0)
    endtask

    task automatic t_ports();
        form(8'he4, 8'h00, 1'b0, 5'h13, 5'h05);
        `CHK(port_byte_out, 1'b1)
        form(8'hed, 8'h00, 1'b0, 5'h14, 5'h05);
        form(8'he6, 8'h00, 1'b0, 5'h15, 5'h03);
        form(8'hef, 8'h00, 1'b0, 5'h16, 5'h03);
        run(8'he4, 8'h00, 1'b1, 2'h3, 2'h0);
        `CHK(exception_out, 1'b1)
        `CHK(exception_vector_out, 8'h0d)
        run(8'hee, 8'h00, 1'b1, 2'h2, 2'h2);
        `CHK(exception_out, 1'b0)
        run(8'he7, 8'h00, 1'b0, 2'h3, 2'h0);
        `CHK(exception_out, 1'b0)
    endtask

    task automatic t_other();
        form(8'hd7, 8'h00, 1'b0, 5'h17, 5'h05);
        form(8'h0f, 8'h00, 1'b0, 5'h00, 5'h00);
        form(8'h1f, 8'h00, 1'b0, 5'h00, 5'h00);
        valid_in = 1'b0;
        @(negedge clk_sys_in);
        `CHK(valid_out, 1'b0)
    endtask

    // ****************************************
    // Clock, reset, sequence
    // ****************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        repeat (2000) @(posedge clk_sys_in);
        failures++;
        summarize();
    end

    initial begin
        resetn_in = 1'b0;
        run(8'h00, 8'h00, 1'b0, 2'h0, 2'h0);
        valid_in = 1'b0;
        repeat (12) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        t_reset();
        t_copies();
        t_segs();
        t_stack();
        t_swaps();
        t_ports();
        t_other();
        summarize();
    end
endmodule
